//--- shared/qps_pkg.sv
// constants and carrier types for the quad pot serial slave port
// assumes a 125 MHz core clock that oversamples the serial pins
`default_nettype none
package qps_pkg;
    localparam int unsigned CLK_MHZ            = 125;                    // core clock rate
    localparam int unsigned NUM_POTS           = 4;                      // potentiometers
    localparam int unsigned WIPER_W            = 7;                      // wiper position width
    localparam logic [6:0]  WIPER_RESET        = 7'h40;                  // mid scale after reset
    localparam logic [7:0]  ID_BYTE            = 8'h50;                  // valid identification byte
    localparam logic [3:0]  OP_READ            = 4'hb;                   // read instruction
    localparam logic [3:0]  OP_WRITE           = 4'hc;                   // write instruction
    localparam logic [3:0]  ADDR_ACR           = 4'h8;                   // access control address
    localparam logic [3:0]  ADDR_LAST_ARRAY    = 4'h6;                   // pointer rolls over after this
    localparam int unsigned ACR_VOL_BIT        = 7;                      // volatile-only access
    localparam int unsigned ACR_RUN_BIT        = 6;                      // power-down bit, 0 = shutdown
    localparam int unsigned ACR_WIP_BIT        = 5;                      // write in progress
    localparam logic [7:0]  ACR_RESET          = 8'h40;                  // run bit 1, vol bit 0
    localparam int unsigned WIPER_SETTLE_NS    = 1500;                   // wiper settle time, ns
    localparam int unsigned WIPER_SETTLE_CYC   = WIPER_SETTLE_NS * CLK_MHZ / 1000; // rounded down
    localparam int unsigned NV_WRITE_MS        = 20;                     // longest nv write, ms
    localparam int unsigned NV_WRITE_CYC       = NV_WRITE_MS * CLK_MHZ * 1000;     // rounded down
    localparam int unsigned FIFO_DEPTH         = 8;                      // write byte buffer depth

    // a byte received from the host, with its register address
    typedef struct packed {
        logic [3:0] addr;                                                // target register
        logic [7:0] data;                                                // byte value
        logic       nv;                                                  // also store non-volatile
    } qps_wr_s;

    // serial engine state
    typedef enum logic [3:0] {
        QPS_IDLE = 4'b0001,                                              // waiting for select fall
        QPS_ID   = 4'b0010,                                              // taking id byte
        QPS_CMD  = 4'b0100,                                              // taking instruction byte
        QPS_DATA = 4'b1000                                               // data bytes
    } qps_state_e;
endpackage
`default_nettype wire

//--- logic/qps_top.sv
// serial slave port, shutdown control and wiper registers of a quad pot
// assumes host drives select, clock and data asynchronously; pins are oversampled
// Contract
// - shutdown opens strings, grounds all wipers
// - wiper registers keep contents through shutdown
// - run equals pin AND register bit
// - serial port works during shutdown
// - wiper tap follows its position register
// - data out only pulls low
// - read bits shift on clock fall
// - input bits sampled on clock rise
// - select low activates the device
// - transfers need a preceding select fall
// - select high releases data out
// - standby when deselected unless nv write
// - wiper reaches new tap within 1.5us
// - nv write self-timed after write sequence
// - mode 0, most significant bit first
// - only read 1011 and write 1100
// - access bit 6 zero means shutdown
// - nv write starts at select rise, 20ms
`timescale 1ns/1ps
`default_nettype none

// byte buffer between serial engine and register file
module qps_fifo #(
    parameter int unsigned WIDTH = 13,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];                                   // storage
    logic [AW:0]      wr_ptr_reg;                                        // write pointer with wrap bit
    logic [AW:0]      rd_ptr_reg;                                        // read pointer with wrap bit
    logic             full;
    logic             empty;
    assign empty       = wr_ptr_reg == rd_ptr_reg;
    assign full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];
    // storage is not reset; only pointers carry control state
    always_ff @(posedge clk_i) begin
        if (in_valid_i && !full) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
    end
    // pointers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (in_valid_i && !full) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (out_ready_i && !empty) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule // qps_fifo

module qps_top #(
    parameter int unsigned NV_WRITE_CYCLES = qps_pkg::NV_WRITE_CYC      // shorten in simulation
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        sck_i,                                      // serial clock pin
    input  wire logic        cs_n_i,                                     // chip select, active low
    input  wire logic        sdi_i,                                      // serial data in
    output logic             sdo_o,                                      // data out level, always 0
    output logic             sdo_oe_n_o,                                 // low while pulling data out low
    input  wire logic        power_down_n_i,                             // shutdown pin, active low
    output logic [27:0]      wiper_terminal_o,                           // four 7-bit tap selects
    output logic             wiper_ground_o,                             // all wipers grounded
    output logic             string_open_o,                              // strings open both ends
    output logic             active_o,                                   // port out of standby
    output logic             nv_busy_o,                                  // nv write running
    output logic [27:0]      nv_value_o                                  // non-volatile initial values
);
    // two-flop synchronisers for the pins
    logic [1:0] sck_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic [1:0] pdn_sync_reg;
    logic       sck_prev_reg;                                            // for edge detection
    logic       cs_prev_reg;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_sync_reg <= 2'h0;
            // select level is unknown at reset; taking it as low means a select held
            // low since power-up never looks like a fall and cannot arm the port
            cs_sync_reg  <= 2'h0;
            sdi_sync_reg <= 2'h0;
            pdn_sync_reg <= 2'h0;
            sck_prev_reg <= 1'b0;
            cs_prev_reg  <= 1'b0;
        end else begin
            sck_sync_reg <= {sck_sync_reg[0], sck_i};
            cs_sync_reg  <= {cs_sync_reg[0], cs_n_i};
            sdi_sync_reg <= {sdi_sync_reg[0], sdi_i};
            pdn_sync_reg <= {pdn_sync_reg[0], power_down_n_i};
            sck_prev_reg <= sck_sync_reg[1];
            cs_prev_reg  <= cs_sync_reg[1];
        end
    end
    logic cs_n;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    assign cs_n     = cs_sync_reg[1];
    assign sck_rise = sck_sync_reg[1] && !sck_prev_reg && !cs_n;
    assign sck_fall = !sck_sync_reg[1] && sck_prev_reg && !cs_n;
    assign cs_fall  = !cs_n && cs_prev_reg;
    assign cs_rise  = cs_n && !cs_prev_reg;

    // serial engine
    qps_pkg::qps_state_e state_reg;
    logic [2:0]          bit_cnt_reg;                                    // bits in current byte
    logic [7:0]          shift_in_reg;                                   // msb first
    logic [7:0]          shift_out_reg;                                  // read data
    logic [3:0]          ptr_reg;                                        // register pointer
    logic                is_read_reg;
    logic                read_drive_reg;                                 // read byte being shifted out
    logic                armed_reg;                                      // saw a select fall since reset
    logic [7:0]          acr_reg;
    logic [6:0]          wiper_reg [qps_pkg::NUM_POTS];
    logic [6:0]          ivr_reg   [qps_pkg::NUM_POTS];
    logic                nv_pending_reg;                                 // nv byte taken this frame
    logic                wip;
    logic [7:0]          byte_in;
    logic                byte_done;
    assign wip       = acr_reg[qps_pkg::ACR_WIP_BIT];
    assign byte_in   = {shift_in_reg[6:0], sdi_sync_reg[1]};
    assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);

    // register read mux
    function automatic logic [7:0] read_reg(input logic [3:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == qps_pkg::ADDR_ACR) begin
            v = acr_reg;
        end else if (a < 4'h4) begin
            v = {1'b0, acr_reg[qps_pkg::ACR_VOL_BIT] ? wiper_reg[a[1:0]] : ivr_reg[a[1:0]]};
        end
        return v;
    endfunction

    // pointer increment with roll over past the array
    function automatic logic [3:0] next_ptr(input logic [3:0] a);
        return (a >= qps_pkg::ADDR_LAST_ARRAY) ? 4'h0 : 4'(a + 4'h1);
    endfunction

    qps_pkg::qps_wr_s wr_item;
    logic             wr_valid;
    logic             fifo_ready;
    // bytes to registers are refused while nv write runs or buffer is full
    assign wr_item  = '{addr: ptr_reg, data: byte_in, nv: !acr_reg[qps_pkg::ACR_VOL_BIT]};
    assign wr_valid = byte_done && (state_reg == qps_pkg::QPS_DATA) && !is_read_reg && !wip;

    // frame sequencing; unarmed or deselected frames are ignored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg   <= qps_pkg::QPS_IDLE;
            bit_cnt_reg <= 3'h0;
            shift_in_reg <= 8'h00;
            ptr_reg     <= 4'h0;
            is_read_reg <= 1'b0;
            armed_reg   <= 1'b0;
        end else if (cs_n) begin
            state_reg   <= qps_pkg::QPS_IDLE;
            bit_cnt_reg <= 3'h0;
        end else begin
            if (cs_fall) begin
                armed_reg <= 1'b1;
                state_reg <= qps_pkg::QPS_ID;
            end
            if (sck_rise && state_reg != qps_pkg::QPS_IDLE) begin
                bit_cnt_reg  <= 3'(bit_cnt_reg + 3'h1);
                shift_in_reg <= byte_in;
            end
            if (byte_done && armed_reg) begin
                unique case (state_reg)
                    qps_pkg::QPS_IDLE: begin
                        state_reg <= qps_pkg::QPS_IDLE;
                    end
                    qps_pkg::QPS_ID: begin
                        state_reg <= (byte_in == qps_pkg::ID_BYTE) ? qps_pkg::QPS_CMD : qps_pkg::QPS_IDLE;
                    end
                    qps_pkg::QPS_CMD: begin
                        ptr_reg     <= byte_in[3:0];
                        is_read_reg <= byte_in[7:4] == qps_pkg::OP_READ;
                        state_reg   <= (byte_in[7:4] == qps_pkg::OP_READ || byte_in[7:4] == qps_pkg::OP_WRITE)
                                       ? qps_pkg::QPS_DATA : qps_pkg::QPS_IDLE;
                    end
                    qps_pkg::QPS_DATA: begin
                        if (ptr_reg != qps_pkg::ADDR_ACR) begin
                            ptr_reg <= next_ptr(ptr_reg);
                        end
                    end
                endcase
            end
        end
    end

    // register under the pointer, taken as a whole byte before any bit select
    logic [7:0] rd_byte;
    assign rd_byte = read_reg(ptr_reg);

    // read shifter: load on the fall that ends the byte before each data byte, shift on falls
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_out_reg  <= 8'h00;
            read_drive_reg <= 1'b0;
            sdo_oe_n_o     <= 1'b1;
        end else if (cs_n) begin
            read_drive_reg <= 1'b0;
            sdo_oe_n_o     <= 1'b1;
        end else if (sck_fall) begin
            if (state_reg == qps_pkg::QPS_DATA && is_read_reg && bit_cnt_reg == 3'h0) begin
                shift_out_reg  <= {rd_byte[6:0], 1'b0};
                read_drive_reg <= 1'b1;
                sdo_oe_n_o     <= rd_byte[7] ? 1'b1 : 1'b0;
            end else if (read_drive_reg) begin
                shift_out_reg <= {shift_out_reg[6:0], 1'b0};
                sdo_oe_n_o    <= shift_out_reg[7] ? 1'b1 : 1'b0;
            end else begin
                sdo_oe_n_o <= 1'b1;
            end
        end
    end
    assign sdo_o = 1'b0;

    // write buffer drained into the registers
    logic             rf_valid;
    logic             rf_ready;
    qps_pkg::qps_wr_s rf_item;
    logic [12:0]      rf_bits;
    assign rf_item  = qps_pkg::qps_wr_s'(rf_bits);
    assign rf_ready = !wip;                                              // stall while nv write runs
    qps_fifo #(
        .WIDTH (13),
        .DEPTH (qps_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (wr_valid),
        .in_ready_o  (fifo_ready),
        .in_data_i   (wr_item),
        .out_valid_o (rf_valid),
        .out_ready_i (rf_ready),
        .out_data_o  (rf_bits)
    );

    // register file; shutdown never touches wiper registers
    logic [31:0] nv_cnt_reg;
    logic        nv_set;                                                 // nv byte landing this cycle
    // a byte landing in the select-rise cycle still starts the write through nv_set; the pending flag clear wins over its set
    assign nv_set = rf_valid && rf_ready && rf_item.nv && (rf_item.addr != qps_pkg::ADDR_ACR);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acr_reg        <= qps_pkg::ACR_RESET;
            nv_pending_reg <= 1'b0;
            nv_cnt_reg     <= 32'h0;
            for (int i = 0; i < qps_pkg::NUM_POTS; i++) begin
                wiper_reg[i] <= qps_pkg::WIPER_RESET;
                ivr_reg[i]   <= qps_pkg::WIPER_RESET;
            end
        end else begin
            if (rf_valid && rf_ready) begin
                if (rf_item.addr == qps_pkg::ADDR_ACR) begin
                    acr_reg[7:6] <= rf_item.data[7:6];
                end else if (rf_item.addr < 4'h4) begin
                    wiper_reg[rf_item.addr[1:0]] <= rf_item.data[6:0];
                    if (rf_item.nv) begin
                        ivr_reg[rf_item.addr[1:0]] <= rf_item.data[6:0];
                        nv_pending_reg <= 1'b1;
                    end
                end else if (rf_item.nv) begin
                    nv_pending_reg <= 1'b1;
                end
            end
            if (cs_rise && (nv_pending_reg || nv_set)) begin
                acr_reg[qps_pkg::ACR_WIP_BIT] <= 1'b1;
                nv_pending_reg <= 1'b0;
                nv_cnt_reg     <= NV_WRITE_CYCLES - 1;
            end else if (wip) begin
                if (nv_cnt_reg == 32'h0) begin
                    acr_reg[qps_pkg::ACR_WIP_BIT] <= 1'b0;
                end else begin
                    nv_cnt_reg <= nv_cnt_reg - 32'h1;
                end
            end
        end
    end

    // pin outputs, one cycle behind the register file (well inside the settle time)
    logic run;
    assign run = pdn_sync_reg[1] & acr_reg[qps_pkg::ACR_RUN_BIT];
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wiper_terminal_o <= {4{qps_pkg::WIPER_RESET}};
            wiper_ground_o   <= 1'b1;
            string_open_o    <= 1'b1;
            active_o         <= 1'b0;
            nv_busy_o        <= 1'b0;
            nv_value_o       <= {4{qps_pkg::WIPER_RESET}};
        end else begin
            wiper_terminal_o <= {wiper_reg[3], wiper_reg[2], wiper_reg[1], wiper_reg[0]};
            wiper_ground_o   <= !run;
            string_open_o    <= !run;
            active_o         <= !cs_n || wip;
            nv_busy_o        <= wip;
            nv_value_o       <= {ivr_reg[3], ivr_reg[2], ivr_reg[1], ivr_reg[0]};
        end
    end

    localparam int SETTLE_MAX = qps_pkg::WIPER_SETTLE_CYC;
    wire unused_ready = fifo_ready;
    sequence read_bit_s;
        sck_fall && read_drive_reg;
    endsequence
    shutdown_ground_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !run |=> wiper_ground_o && string_open_o) else $error("shutdown not grounding");
    shutdown_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!run && !(rf_valid && rf_ready)) |=> $stable(wiper_reg[0])) else $error("wiper lost in shutdown");
    run_and_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pdn_sync_reg[1] && acr_reg[qps_pkg::ACR_RUN_BIT]) |=> !wiper_ground_o && !string_open_o)
        else $error("run not and");
    open_drain_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sdo_o == 1'b0) else $error("data out driven high");
    deselect_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cs_n |=> sdo_oe_n_o) else $error("data out driven while deselected");
    drive_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(sdo_oe_n_o) |-> $past(sck_fall)) else $error("drive off clock fall");
    wiper_settle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rf_valid && rf_ready && rf_item.addr == 4'h0) |-> ##[1:SETTLE_MAX]
        (wiper_terminal_o[6:0] == wiper_reg[0])) else $error("wiper slow");
    standby_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cs_n && !wip) |=> !active_o) else $error("not standby");
    read_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!read_drive_reg && !sck_fall) |=> $stable(sdo_oe_n_o) || sdo_oe_n_o) else $error("stray drive");
    read_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        read_bit_s ##1 cs_n |=> sdo_oe_n_o) else $error("data out held after select rise");
endmodule // qps_top
`default_nettype wire

//--- dv/qps_host.sv
// spi host model driving the quad pot serial port, mode 0, msb first
// assumes the 125 MHz bench clock; a serial half period is five of its cycles
`timescale 1ns/1ps
`default_nettype none
module qps_host (
    input  wire logic clk_i,   // bench clock
    input  wire logic sdo_i,   // data out line after the pull-up
    output logic      sck_o,   // serial clock, low outside frames
    output logic      cs_n_o,  // chip select, active low
    output logic      sdi_o    // serial data to the slave
);
    // select starts low so the first bytes after reset carry no select fall
    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b0;
        sdi_o  = 1'b0;
    end
    // one half period of the 80 ns serial clock
    task automatic half();
        repeat (5) @(posedge clk_i);
        #1;
    endtask
    // one byte each way; sdi moves while sck is low, sdo is taken at the rise
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 7; b >= 0; b--) begin
            sdi_o = tx[b];
            half();
            sck_o = 1'b1;
            rx[b] = sdo_i;
            half();
            sck_o = 1'b0;
        end
    endtask
    // whole frame: deselect gap, select fall, id, instruction, n data bytes
    task automatic frame(input logic [7:0] id, input logic [7:0] op, input logic [31:0] d, input int n,
                         output logic [7:0] rx);
        logic [7:0] junk;
        cs_n_o = 1'b1;
        repeat (50) half();
        cs_n_o = 1'b0;
        repeat (7) half(); // lead time
        xbyte(id, junk);
        xbyte(op, junk);
        for (int i = 0; i < n; i++) begin
            xbyte(d[8*(n-1-i) +: 8], rx);
        end
        repeat (7) half(); // lag time before the select rise
        cs_n_o = 1'b1;
        repeat (7) half();
    endtask
endmodule // qps_host
`default_nettype wire

//--- dv/tb_quad_pot_spi_slave_port.sv
// self-checking bench for the quad pot serial slave port
// assumes qps_pkg and qps_top compiled first; the host model drives the pins
`timescale 1ns/1ps
`default_nettype none
module tb_quad_pot_spi_slave_port;
    localparam int unsigned NV_CYC = 200; // shortened nv write so the run stays short
    typedef struct packed {
        logic [7:0] op;   // instruction and address
        logic [7:0] data; // data byte
        logic [6:0] tap;  // tap the pot should take
    } qps_row_s;
    qps_row_s    rows [4] = '{'{8'hc0, 8'h00, 7'h00}, '{8'hc1, 8'h7f, 7'h7f},
                              '{8'hc2, 8'h55, 7'h55}, '{8'hc3, 8'h2a, 7'h2a}};
    logic        clk_i, rst_i, power_down_n_i;   // bench driven
    logic        sck, cs_n, sdi, sdo, sdo_oe_n;  // serial pins
    logic        sdo_line;                       // resolved open-drain wire
    logic [27:0] wiper, nv_value, exp_wiper;     // tap outputs and model
    logic        ground, str_open, active, nv_busy;
    logic [7:0]  rx;                             // last byte read back
    int          failures = 0;
    int          n_compared = 0;
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo; // pull-up wins when released
    // free running 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    qps_top #(.NV_WRITE_CYCLES(NV_CYC)) i_qps_top (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .power_down_n_i(power_down_n_i),
        .wiper_terminal_o(wiper), .wiper_ground_o(ground), .string_open_o(str_open), .active_o(active),
        .nv_busy_o(nv_busy), .nv_value_o(nv_value));
    qps_host i_qps_host (.clk_i(clk_i), .sdo_i(sdo_line), .sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi));
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    // verdict and end of run
    task automatic results();
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // frame with the valid id byte
    task automatic wr(input logic [7:0] op, input logic [31:0] d, input int n);
        i_qps_host.frame(qps_pkg::ID_BYTE, op, d, n, rx);
    endtask
    // a hang counts as a mismatch
    initial begin
        #500000;
        failures++;
        results();
    end
    // main sequence
    initial begin
        rst_i = 1'b1;
        power_down_n_i = 1'b1;
        exp_wiper = {4{qps_pkg::WIPER_RESET}};
        repeat (6) @(posedge clk_i);
        #1;
        check({ground, str_open, sdo_oe_n, active, nv_busy}, 5'h1c);
        rst_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        check(wiper, exp_wiper);
        check(ground, 1'b0);
        // bytes with select low since reset, no fall: must be ignored
        i_qps_host.xbyte(qps_pkg::ID_BYTE, rx);
        i_qps_host.xbyte(8'hc0, rx);
        i_qps_host.xbyte(8'h11, rx);
        check(wiper, exp_wiper);
        wr(8'hc8, 8'hc0, 1); // volatile access only
        for (int i = 0; i < 4; i++) begin
            wr(rows[i].op, rows[i].data, 1);
            exp_wiper[7*rows[i].op[1:0] +: 7] = rows[i].tap;
            check(wiper, exp_wiper);
            check(sdo_oe_n, 1'b1);
        end
        wr(8'hb2, 8'h00, 1);
        check(rx, {1'b0, rows[2].tap});
        check(sdo, 1'b0);
        // burst from address 5 rolls over after 6 onto pots 0 and 1
        wr(8'hc5, 32'h01020304, 4);
        exp_wiper[6:0] = 7'h03;
        exp_wiper[13:7] = 7'h04;
        check(wiper, exp_wiper);
        // bad instruction codes and a bad id are ignored
        wr(8'hd0, 8'h77, 1);
        wr(8'ha1, 8'h77, 1);
        i_qps_host.frame(8'h51, 8'hc0, 8'h77, 1, rx);
        check(wiper, exp_wiper);
        // pin shutdown keeps registers and the port
        power_down_n_i = 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
        check({ground, str_open}, 2'h3);
        wr(8'hc2, 8'h11, 1);
        exp_wiper[20:14] = 7'h11;
        check(wiper, exp_wiper);
        power_down_n_i = 1'b1;
        repeat (10) @(posedge clk_i);
        #1;
        check({ground, str_open}, 2'h0);
        wr(8'hc8, 8'h80, 1);
        check({ground, str_open}, 2'h3);
        wr(8'hc8, 8'hc0, 1);
        check({ground, str_open}, 2'h0);
        // non-volatile write runs alone after the select rise
        wr(8'hc8, 8'h40, 1);
        wr(8'hc3, 8'h33, 1);
        exp_wiper[27:21] = 7'h33;
        check(wiper, exp_wiper);
        check({nv_busy, active}, 2'h3);
        check(nv_value[27:21], 7'h33);
        repeat (NV_CYC) @(posedge clk_i);
        #1;
        check({nv_busy, active}, 2'h0);
        // with volatile-only access off a read returns the stored initial value
        wr(8'hb3, 8'h00, 1);
        check(rx, {1'b0, 7'h33});
        // access control reads back run bit set, write done
        wr(8'hb8, 8'h00, 1);
        check(rx, 8'h40);
        results();
    end
endmodule // tb_quad_pot_spi_slave_port
`default_nettype wire
